// ---- rtl/hiem_defines.svh ----
// Constants for the interrupt enable, identification and scratch block.
// Assumes inclusion by bare name from the package, the link checker and the bench.
`ifndef HIEM_DEFINES_SVH
`define HIEM_DEFINES_SVH

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define HIEM_CMD_ENABLE_RD 8'h25
`define HIEM_CMD_ENABLE_WR 8'ha5
`define HIEM_CMD_IDENT_RD 8'h27
`define HIEM_CMD_SCRATCH_RD 8'h28
`define HIEM_CMD_SCRATCH_WR 8'ha8
`define HIEM_CMD_BUFSTAT_RD 8'h2c
`define HIEM_CMD_DMACFG_WR 8'ha1
`define HIEM_CMD_ISO_DATA_RD 8'h40
`define HIEM_CMD_ISO_DMA_GO 8'hc0
`define HIEM_CMD_HOST_STATUS 8'hff

// ----------------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------------
`define HIEM_EVENT_COUNT 10
`define HIEM_ENABLE_MASK 16'h03ff
`define HIEM_ENABLE_RESET 16'h0000
`define HIEM_SCRATCH_RESET 16'h0000
`define HIEM_FRAME_START_BIT 0
// Arbitrary identification value: product byte, revision byte
`define HIEM_IDENT_VALUE 16'h5a01

// ----------------------------------------------------------------------
// Host status fields
// ----------------------------------------------------------------------
`define HIEM_HS_PENDING_BIT 0
`define HIEM_HS_DMACFG_BIT 1
`define HIEM_HS_REFUSED_BIT 2

`endif

// ---- rtl/hiem_pkg.sv ----
// Types shared by both ends of the enable, identification and scratch link.
// Assumes hiem_defines.svh is on the include path.
`default_nettype none
`include "hiem_defines.svh"

package hiem_pkg;
  typedef logic [7:0] hiem_cmd_t;
  typedef logic [15:0] hiem_word_t;
  typedef logic [`HIEM_EVENT_COUNT-1:0] hiem_events_t;
endpackage

`default_nettype wire

// ---- rtl/hiem_link_if.sv ----
// Command link between the processor end and the device end.
// Assumes one shared clock; every signal is synchronous to it.
`timescale 1ns/1ps
`default_nettype none

interface hiem_link_if
  import hiem_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in
);
  logic cmd_valid;
  hiem_cmd_t cmd_code;
  hiem_word_t cmd_wdata;
  hiem_word_t rsp_rdata;
  logic irq;
  logic frame_start;

  modport device_mp (
    input cmd_valid,
    input cmd_code,
    input cmd_wdata,
    output rsp_rdata,
    output irq,
    output frame_start
  );

  modport host_mp (
    output cmd_valid,
    output cmd_code,
    output cmd_wdata,
    input rsp_rdata,
    input irq,
    input frame_start
  );
endinterface

`default_nettype wire

// ---- rtl/hiem_device.sv ----
// Device end: enable mask, identification and scratch registers with the
// gating of ten controller events onto the processor interrupt output.
// Assumes the event status and the global enable come from neighbouring
// controller logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module hiem_device
  import hiem_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  hiem_link_if.device_mp link,
  input wire logic [9:0] interrupt_status_register_in,
  input wire logic global_irq_enable_in,
  output logic processor_interrupt_output_out,
  output logic frame_start_state_out,
  output logic [15:0] interrupt_enable_mask_out
);

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  hiem_word_t enable_reg;
  hiem_word_t scratch_reg;
  logic irq_reg;
  logic frame_start_reg;
  hiem_word_t rdata;

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      enable_reg <= `HIEM_ENABLE_RESET;
    else if (link.cmd_valid && link.cmd_code == `HIEM_CMD_ENABLE_WR)
      enable_reg <= link.cmd_wdata & `HIEM_ENABLE_MASK;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      scratch_reg <= `HIEM_SCRATCH_RESET;
    else if (link.cmd_valid && link.cmd_code == `HIEM_CMD_SCRATCH_WR)
      scratch_reg <= link.cmd_wdata;
  end

  // --------------------------------------------------------------------
  // Interrupt gating
  // --------------------------------------------------------------------
  // Bit order: 9 dual-role, 8 async list, 7 periodic list, 6 clock ready,
  // 5 suspended, 4 operational regs, 3 end of transfer, 2 iso B,
  // 1 iso A, 0 frame start.
  hiem_events_t gated;
  assign gated = interrupt_status_register_in & enable_reg[9:0];

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      irq_reg <= 1'b0;
    else
      irq_reg <= global_irq_enable_in && (|gated);
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      frame_start_reg <= 1'b0;
    else
      frame_start_reg <= interrupt_status_register_in[`HIEM_FRAME_START_BIT];
  end

  // --------------------------------------------------------------------
  // Read decode
  // --------------------------------------------------------------------
  // Reads answer within the cycle; the processor end registers them.
  // No write code exists for identification, so A7h falls to default.
  always_comb
  begin
    if (link.cmd_code == `HIEM_CMD_ENABLE_RD)
      rdata = enable_reg;
    else if (link.cmd_code == `HIEM_CMD_IDENT_RD)
      rdata = `HIEM_IDENT_VALUE;
    else if (link.cmd_code == `HIEM_CMD_SCRATCH_RD)
      rdata = scratch_reg;
    else
      rdata = 16'h0000;
  end

  assign link.rsp_rdata = rdata;
  assign link.irq = irq_reg;
  assign link.frame_start = frame_start_reg;
  assign processor_interrupt_output_out = irq_reg;
  assign frame_start_state_out = frame_start_reg;
  assign interrupt_enable_mask_out = enable_reg;

endmodule

`default_nettype wire

// ---- rtl/hiem_host.sv ----
// Processor end: turns software strobes into link commands and keeps the
// frame-start and DMA ordering that the device relies on.
// Assumes software strobes are one cycle, never both at once.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module hiem_host
  import hiem_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  hiem_link_if.host_mp link,
  input wire logic [7:0] addr_in,
  input wire logic [15:0] wr_data_in,
  input wire logic wr_strobe_in,
  input wire logic rd_strobe_in,
  output logic [15:0] rd_data_out,
  output logic irq_out
);

  // --------------------------------------------------------------------
  // Ordering guards
  // --------------------------------------------------------------------
  // An iso data read is refused while a frame start awaits a buffer
  // status read; an iso DMA start is refused until DMA is configured.
  logic pending_reg;
  logic dmacfg_reg;
  logic refused_reg;
  logic frame_start_d_reg;
  logic frame_rise;
  logic blocked;
  logic is_local;
  hiem_word_t rd_data_reg;

  assign frame_rise = link.frame_start && !frame_start_d_reg;
  assign is_local = addr_in == `HIEM_CMD_HOST_STATUS;
  assign blocked = (rd_strobe_in && addr_in == `HIEM_CMD_ISO_DATA_RD && pending_reg)
                || (wr_strobe_in && addr_in == `HIEM_CMD_ISO_DMA_GO && !dmacfg_reg);

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      frame_start_d_reg <= 1'b0;
    else
      frame_start_d_reg <= link.frame_start;
  end

  // A frame start in the same cycle as the status read wins
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      pending_reg <= 1'b0;
    else if (frame_rise)
      pending_reg <= 1'b1;
    else if (rd_strobe_in && addr_in == `HIEM_CMD_BUFSTAT_RD)
      pending_reg <= 1'b0;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      dmacfg_reg <= 1'b0;
    else if (wr_strobe_in && addr_in == `HIEM_CMD_DMACFG_WR)
      dmacfg_reg <= 1'b1;
  end

  // Sticky; cleared by reading host status, a new refusal wins
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      refused_reg <= 1'b0;
    else if (blocked)
      refused_reg <= 1'b1;
    else if (rd_strobe_in && is_local)
      refused_reg <= 1'b0;
  end

  // --------------------------------------------------------------------
  // Link drive and read capture
  // --------------------------------------------------------------------
  assign link.cmd_valid = (wr_strobe_in || rd_strobe_in) && !blocked && !is_local;
  assign link.cmd_code = addr_in;
  assign link.cmd_wdata = wr_data_in;

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rd_data_reg <= 16'h0000;
    else if (rd_strobe_in && is_local)
    begin
      rd_data_reg <= 16'h0000;
      rd_data_reg[`HIEM_HS_PENDING_BIT] <= pending_reg;
      rd_data_reg[`HIEM_HS_DMACFG_BIT] <= dmacfg_reg;
      rd_data_reg[`HIEM_HS_REFUSED_BIT] <= refused_reg;
    end
    else if (rd_strobe_in && !blocked)
      rd_data_reg <= link.rsp_rdata;
    else if (rd_strobe_in)
      rd_data_reg <= 16'h0000;
  end

  assign rd_data_out = rd_data_reg;
  assign irq_out = link.irq;

endmodule

`default_nettype wire

// ---- test/hiem_assertions.sv ----
// Link checker for the enable, identification and scratch block.
// Assumes the bench top feeds the link signals in by name.
`timescale 1ns/1ps
`default_nettype none
`include "hiem_defines.svh"

module hiem_assertions
  import hiem_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic cmd_valid,
  input wire hiem_cmd_t cmd_code,
  input wire hiem_word_t cmd_wdata,
  input wire hiem_word_t rsp_rdata,
  input wire logic irq,
  input wire logic frame_start
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  chk_ident_value:
    assert property (cmd_valid && cmd_code == 8'h27 |-> rsp_rdata == `HIEM_IDENT_VALUE)
    else $error("identification value wrong");
  chk_enable_reserved_zero:
    assert property (cmd_valid && cmd_code == 8'h25 |-> rsp_rdata[15:10] == 6'h00)
    else $error("reserved enable bits not zero");
  chk_enable_write_read:
    assert property ((cmd_valid && cmd_code == 8'ha5) ##1 (cmd_valid && cmd_code == 8'h25)
      |-> rsp_rdata == ($past(cmd_wdata) & 16'h03ff))
    else $error("enable readback differs from write");
  chk_scratch_write_read:
    assert property ((cmd_valid && cmd_code == 8'ha8) ##1 (cmd_valid && cmd_code == 8'h28)
      |-> rsp_rdata == $past(cmd_wdata))
    else $error("scratch readback differs from write");
  chk_enable_holds:
    assert property ((cmd_valid && cmd_code == 8'h25) ##1 (cmd_valid && cmd_code == 8'h25)
      |-> $stable(rsp_rdata))
    else $error("enable changed without a write");
  chk_ident_steady:
    assert property ((cmd_valid && cmd_code == 8'h27) ##1 (cmd_valid && cmd_code == 8'h27)
      |-> $stable(rsp_rdata))
    else $error("identification changed");
  chk_reset_quiet:
    assert property ($rose(rst_n_in) |-> !irq && !frame_start)
    else $error("outputs active after reset");
  chk_mask_blocks_irq:
    assert property (cmd_valid && cmd_code == 8'h25 && rsp_rdata == 16'h0000 |=> !irq)
    else $error("interrupt with all enables clear");

  cover property (cmd_valid && cmd_code == 8'ha5);
  cover property ($rose(irq));
  cover property ($rose(frame_start));
endmodule

`default_nettype wire

// ---- test/host_irq_enable_misc_regs_tb.sv ----
// Bench for both link ends of the enable, identification and scratch block.
// Assumes the link interface and both ends compile before it.
`timescale 1ns/1ps
`default_nettype none
`include "hiem_defines.svh"
`define CHK(nm, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      n_errors++; \
      $display("unexpected %s exp %h got %h", nm, exp, got); \
    end \
  end

module host_irq_enable_misc_regs_tb
  import hiem_pkg::*;
;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] addr = 8'h00;
  hiem_word_t wdata = 16'h0000;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  hiem_events_t status = 10'h000;
  logic glob = 1'b0;
  hiem_word_t rdata;
  hiem_word_t mask_o;
  logic irq_o;
  logic dev_irq;
  logic frame_o;
  int n_errors = 0;
  int comparisons = 0;

  always #4 clk_sys_in = ~clk_sys_in;

  hiem_link_if i_hiem_link_if (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in));
  hiem_device i_hiem_device (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .link(i_hiem_link_if), .interrupt_status_register_in(status),
    .global_irq_enable_in(glob), .processor_interrupt_output_out(dev_irq),
    .frame_start_state_out(frame_o), .interrupt_enable_mask_out(mask_o));
  hiem_host i_hiem_host (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .link(i_hiem_link_if), .addr_in(addr), .wr_data_in(wdata), .wr_strobe_in(wr_s),
    .rd_strobe_in(rd_s), .rd_data_out(rdata), .irq_out(irq_o));
  hiem_assertions i_hiem_assertions (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .cmd_valid(i_hiem_link_if.cmd_valid), .cmd_code(i_hiem_link_if.cmd_code),
    .cmd_wdata(i_hiem_link_if.cmd_wdata), .rsp_rdata(i_hiem_link_if.rsp_rdata),
    .irq(i_hiem_link_if.irq), .frame_start(i_hiem_link_if.frame_start));

  // ----------------------------------------------------------------
  // Register port tasks
  // ----------------------------------------------------------------
  // Called just after an edge; returns 1 ns past the taking edge, so calls
  // chain with no gap and no strobe is assigned twice in one time step
  task automatic wr(input logic [7:0] a, input hiem_word_t d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk_sys_in);
    wr_s <= 1'b0;
    #1;
  endtask

  // Empty name reads without comparing
  task automatic rd(input logic [7:0] a, input hiem_word_t exp, input string nm);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_sys_in);
    rd_s <= 1'b0;
    #1;
    if (nm != "")
      `CHK(nm, exp, rdata)
  endtask

  // Irq is registered one cycle after the enable
  task automatic settle;
    repeat (3) @(posedge clk_sys_in);
    #1;
  endtask

  task automatic wrap_up;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    #100000;
    n_errors++;
    wrap_up;
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    rd(8'h25, 16'h0000, "enable reset");
    @(posedge clk_sys_in) status <= 10'h3ff;
    glob <= 1'b1;
    settle;
    `CHK("irq masked", 1'b0, irq_o)
    for (int i = 0; i < 10; i++)
    begin
      wr(8'ha5, 16'h0001 << i);
      @(posedge clk_sys_in) status <= 10'h3ff ^ (10'h001 << i);
      settle;
      `CHK("irq other bit", 1'b0, irq_o)
      @(posedge clk_sys_in) status <= 10'h001 << i;
      settle;
      `CHK("irq own bit", 1'b1, irq_o)
      `CHK("device irq", 1'b1, dev_irq)
      @(posedge clk_sys_in) glob <= 1'b0;
      settle;
      `CHK("irq global off", 1'b0, irq_o)
      @(posedge clk_sys_in) glob <= 1'b1;
    end
    wr(8'ha5, 16'hffff);
    rd(8'h25, 16'h03ff, "enable reserved");
    `CHK("mask out", 16'h03ff, mask_o)
    wr(8'ha5, 16'h0000);
    rd(8'h25, 16'h0000, "enable cleared");
    rd(8'h25, 16'h0000, "enable steady");
    rd(8'h27, `HIEM_IDENT_VALUE, "ident");
    wr(8'h27, 16'hffff);
    wr(8'ha7, 16'hffff);
    rd(8'h27, `HIEM_IDENT_VALUE, "ident after write");
    rd(8'h27, `HIEM_IDENT_VALUE, "ident repeat");
    wr(8'ha8, 16'ha5c3);
    rd(8'h28, 16'ha5c3, "scratch");
    rd(8'h33, 16'h0000, "unmapped");
    @(posedge clk_sys_in) status <= 10'h000;
    rd(8'h2c, 16'h0000, "");
    rd(8'hff, 16'h0000, "host idle");
    @(posedge clk_sys_in) status <= 10'h001;
    settle;
    `CHK("frame start", 1'b1, frame_o)
    `CHK("link frame start", 1'b1, i_hiem_link_if.frame_start)
    rd(8'h40, 16'h0000, "iso refused");
    rd(8'hff, 16'h0005, "pending refused");
    rd(8'h2c, 16'h0000, "");
    rd(8'hff, 16'h0000, "pending cleared");
    wr(8'hc0, 16'h0000);
    rd(8'hff, 16'h0004, "dma refused");
    wr(8'ha1, 16'h0001);
    wr(8'hc0, 16'h0000);
    rd(8'hff, 16'h0002, "dma accepted");
    wrap_up;
  end
endmodule

`default_nettype wire
